// File: core/bus_event_pkg.sv
// Constants and types for the bus and cache event counter
package bus_event_pkg;
  // ****************************************
  // Event codes and unit masks
  // ****************************************
  localparam logic [7:0] EV_PREFETCH    = 8'h4e;
  localparam logic [7:0] UM_PREFETCH    = 8'h10;
  localparam logic [7:0] EV_OUTSTANDING = 8'h60;
  localparam logic [7:0] EV_HOLD_OFF    = 8'h61;
  localparam logic [7:0] EV_DATA_VALID  = 8'h62;
  localparam logic [7:0] EV_ATOMIC      = 8'h63;
  localparam logic [7:0] EV_RECEIVE     = 8'h64;
  localparam logic [7:0] EV_BURST_READ  = 8'h65;
  localparam logic [7:0] UM_OWN         = 8'h40;
  localparam logic [7:0] UM_ALL         = 8'hc0;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [11:0] OFF_SELECT = 12'h000;
  localparam logic [11:0] OFF_COUNT  = 12'h004;
  localparam logic [11:0] OFF_THRESH = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam int          SEL_ENABLE = 16;
  localparam int          SEL_RETRY  = 17;
  localparam logic [17:0] SELECT_RST = 18'h0_0000;
  localparam logic [3:0]  THRESH_RST = 4'hc;
  localparam logic [3:0]  PEND_RST   = 4'h0;
  localparam logic [31:0] COUNT_RST  = 32'h0000_0000;
  // ****************************************
  // Bus carriers
  // ****************************************
  typedef enum logic [2:0] {REQ_L1D_READ, REQ_L2_PREFETCH, REQ_RFO, REQ_IFETCH, REQ_OTHER} req_kind_t;
  typedef struct packed {
    logic      valid;
    req_kind_t kind;
    logic      cacheable;
  } bus_req_t;
  typedef struct packed {
    logic       line_done;
    logic       data_strobe;
    logic       atomic;
    logic       receiving;
    logic       hold_off;
    logic [3:0] txn_count;
  } bus_obs_t;
  typedef struct packed {
    logic hold_off;
    logic data_strobe;
    logic atomic;
  } bus_drive_t;
  typedef enum logic [1:0] {HOLD_IDLE, HOLD_FIRST, HOLD_SECOND} hold_state_t;
endpackage

// File: core/bus_cache_event_counting.sv
// Bus and cache event detection, bus drive and APB-programmed event counter
`timescale 1ns/1ps
module bus_cache_event_counting (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [11:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire bus_event_pkg::bus_req_t   req_in,
  output bus_event_pkg::bus_req_t        req_grant,
  input  wire bus_event_pkg::bus_obs_t   obs,
  output bus_event_pkg::bus_drive_t      drive,
  input  wire logic                      own_data,
  input  wire logic                      lock_uc,
  input  wire logic                      lock_split,
  input  wire logic                      lock_walk,
  input  wire logic                      pf_req,
  input  wire logic                      l2_busy,
  output logic                           pf_accept,
  output logic                           pf_drop
);
  function automatic logic ev_match(input logic [17:0] sel, input logic [7:0] ev, input logic [7:0] um);
    ev_match = sel[bus_event_pkg::SEL_ENABLE] && (sel[7:0] == ev) && (sel[15:8] == um);
  endfunction

  // ****************************************
  // APB register slave
  // ****************************************
  logic [17:0] select_q, select_d;
  logic [3:0]  thresh_q, thresh_d;
  logic [31:0] count_q, count_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d;
  logic        setup, wr_access, cnt_wr, retry_en;
  logic [3:0]  pending_q, pending_d;
  logic        retry_q, retry_d;
  bus_event_pkg::hold_state_t hold_q, hold_d;

  always_comb
  begin
    setup     = psel && !penable;
    wr_access = psel && penable && pready && pwrite;
    cnt_wr    = wr_access && (paddr == bus_event_pkg::OFF_COUNT);
    retry_en  = select_q[bus_event_pkg::SEL_RETRY];
    select_d  = select_q;
    thresh_d  = thresh_q;
    if (wr_access && paddr == bus_event_pkg::OFF_SELECT)
    begin
      select_d = pwdata[17:0];
    end
    if (wr_access && paddr == bus_event_pkg::OFF_THRESH)
    begin
      thresh_d = pwdata[3:0];
    end
    pready_d  = setup;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        bus_event_pkg::OFF_SELECT: prdata_d = {14'h0000, select_q};
        bus_event_pkg::OFF_COUNT:  prdata_d = count_q;
        bus_event_pkg::OFF_THRESH: prdata_d = {28'h000_0000, thresh_q};
        bus_event_pkg::OFF_STATUS: prdata_d = {26'h000_0000, retry_q, drive.hold_off, pending_q};
        default:                   pslverr_d = 1'b1;
      endcase
    end
    else if (setup)
    begin
      pslverr_d = !(paddr == bus_event_pkg::OFF_SELECT || paddr == bus_event_pkg::OFF_COUNT
                    || paddr == bus_event_pkg::OFF_THRESH || paddr == bus_event_pkg::OFF_STATUS);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      select_q <= bus_event_pkg::SELECT_RST;
      thresh_q <= bus_event_pkg::THRESH_RST;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      select_q <= select_d;
      thresh_q <= thresh_d;
      prdata   <= prdata_d;
      pready   <= pready_d;
      pslverr  <= pslverr_d;
    end
  end

  // ****************************************
  // Hold-off drive and request issue
  // ****************************************
  bus_event_pkg::bus_drive_t drive_d;
  bus_event_pkg::bus_req_t   grant_d;
  logic pend_read;

  always_comb
  begin
    unique case (hold_q)
      bus_event_pkg::HOLD_IDLE:   hold_d = (obs.txn_count >= thresh_q) ? bus_event_pkg::HOLD_FIRST
                                                                       : bus_event_pkg::HOLD_IDLE;
      bus_event_pkg::HOLD_FIRST:  hold_d = bus_event_pkg::HOLD_SECOND;
      bus_event_pkg::HOLD_SECOND: hold_d = bus_event_pkg::HOLD_IDLE;
      default:                    hold_d = bus_event_pkg::HOLD_IDLE;
    endcase
    drive_d.hold_off    = (hold_d != bus_event_pkg::HOLD_IDLE);
    drive_d.data_strobe = own_data;
    drive_d.atomic      = lock_uc || lock_split || lock_walk;
    // Own hold-off for next cycle and any seen from others both block issue
    grant_d       = req_in;
    grant_d.valid = req_in.valid && !drive_d.hold_off && !obs.hold_off;
    pend_read = req_grant.valid && req_grant.cacheable
                && (req_grant.kind == bus_event_pkg::REQ_L1D_READ
                    || req_grant.kind == bus_event_pkg::REQ_L2_PREFETCH);
    pending_d = pending_q + {3'b000, pend_read} - {3'b000, obs.line_done && pending_q != 4'h0};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q    <= bus_event_pkg::HOLD_IDLE;
      drive     <= '0;
      req_grant <= '0;
      pending_q <= bus_event_pkg::PEND_RST;
    end
    else
    begin
      hold_q    <= hold_d;
      drive     <= drive_d;
      req_grant <= grant_d;
      pending_q <= pending_d;
    end
  end

  // ****************************************
  // Prefetch request path
  // ****************************************
  logic pf_present, pf_refused, pf_accept_d, pf_drop_d;

  always_comb
  begin
    pf_present  = pf_req || retry_q;
    pf_refused  = pf_present && l2_busy;
    retry_d     = pf_refused && retry_en;
    pf_accept_d = pf_present && !l2_busy;
    pf_drop_d   = pf_refused && !retry_en;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retry_q   <= 1'b0;
      pf_accept <= 1'b0;
      pf_drop   <= 1'b0;
    end
    else
    begin
      retry_q   <= retry_d;
      pf_accept <= pf_accept_d;
      pf_drop   <= pf_drop_d;
    end
  end

  // ****************************************
  // Event counter
  // ****************************************
  logic [31:0] incr;
  logic        burst_read;

  always_comb
  begin
    burst_read = req_grant.valid && req_grant.cacheable
                 && req_grant.kind != bus_event_pkg::REQ_RFO
                 && req_grant.kind != bus_event_pkg::REQ_OTHER;
    incr = 32'h0000_0000;
    if (ev_match(select_q, bus_event_pkg::EV_PREFETCH, bus_event_pkg::UM_PREFETCH))
    begin
      incr = {31'h0000_0000, pf_present};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_OUTSTANDING, bus_event_pkg::UM_OWN))
    begin
      incr = {28'h000_0000, pending_q};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_HOLD_OFF, bus_event_pkg::UM_OWN))
    begin
      incr = {31'h0000_0000, hold_q == bus_event_pkg::HOLD_FIRST};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_DATA_VALID, bus_event_pkg::UM_OWN))
    begin
      incr = {31'h0000_0000, drive.data_strobe};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_DATA_VALID, bus_event_pkg::UM_ALL))
    begin
      incr = {31'h0000_0000, drive.data_strobe || obs.data_strobe};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_ATOMIC, bus_event_pkg::UM_OWN))
    begin
      incr = {31'h0000_0000, drive.atomic};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_ATOMIC, bus_event_pkg::UM_ALL))
    begin
      incr = {31'h0000_0000, drive.atomic || obs.atomic};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_RECEIVE, bus_event_pkg::UM_OWN))
    begin
      incr = {31'h0000_0000, obs.receiving};
    end
    else if (ev_match(select_q, bus_event_pkg::EV_BURST_READ, bus_event_pkg::UM_OWN))
    begin
      incr = {31'h0000_0000, burst_read};
    end
    // Software load of the count wins over a same-cycle increment
    count_d = cnt_wr ? pwdata : count_q + incr;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= bus_event_pkg::COUNT_RST;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence hold_pulse_s;
    drive.hold_off ##1 drive.hold_off ##1 !drive.hold_off;
  endsequence

  hold_two_cycles_a: assert property ($rose(drive.hold_off) |-> hold_pulse_s)
    else $error("hold-off pulse not two cycles");
  hold_trigger_a: assert property ((hold_q == bus_event_pkg::HOLD_IDLE && obs.txn_count >= thresh_q)
                                   |=> drive.hold_off)
    else $error("hold-off not raised near capacity");
  no_issue_hold_a: assert property (drive.hold_off |-> !req_grant.valid)
    else $error("request issued during hold-off");
  strobe_follow_a: assert property (own_data |=> drive.data_strobe)
    else $error("data strobe missing");
  lock_drive_a: assert property ((lock_uc || lock_split || lock_walk) |=> drive.atomic)
    else $error("atomic lock not driven");
  retry_resubmit_a: assert property ((pf_refused && retry_en) |=> (retry_q && pf_present))
    else $error("refused prefetch not resubmitted");
  prefetch_count_a: assert property ((ev_match(select_q, bus_event_pkg::EV_PREFETCH, bus_event_pkg::UM_PREFETCH)
                                      && pf_present && !cnt_wr) |=> count_q == $past(count_q) + 32'h0000_0001)
    else $error("prefetch request not counted");
  pending_add_a: assert property ((ev_match(select_q, bus_event_pkg::EV_OUTSTANDING, bus_event_pkg::UM_OWN)
                                   && !cnt_wr) |=> count_q == $past(count_q) + {28'h000_0000, $past(pending_q)})
    else $error("pending reads not added in full");
  rfo_excluded_a: assert property ((ev_match(select_q, bus_event_pkg::EV_BURST_READ, bus_event_pkg::UM_OWN)
                                    && req_grant.kind == bus_event_pkg::REQ_RFO && !cnt_wr)
                                   |=> $stable(count_q))
    else $error("read-for-ownership counted as burst read");
  idle_counter_a: assert property ((!select_q[bus_event_pkg::SEL_ENABLE] && !cnt_wr) |=> $stable(count_q))
    else $error("counter moved without a matching event");
endmodule // bus_cache_event_counting

// File: sim/bus_agents_model.sv
// Behavioural model of the other agents sharing the system bus
`timescale 1ns/1ps
module bus_agents_model (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [3:0]                cmd,
  input  wire bus_event_pkg::bus_drive_t drive,
  output bus_event_pkg::bus_obs_t        obs
);
  logic [3:0] cmd_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      cmd_q <= 4'h0;
    else
      cmd_q <= cmd;
  // Data strobe is the wired sum of our drive and the other agents'; atomic and hold-off echo our drives alone
  always_comb
  begin
    obs.line_done   = cmd_q[0];
    obs.data_strobe = cmd_q[1] | drive.data_strobe;
    obs.atomic      = drive.atomic;
    obs.receiving   = cmd_q[2];
    obs.hold_off    = drive.hold_off;
    obs.txn_count   = cmd_q[3] ? 4'h3 : 4'h0;
  end
endmodule // bus_agents_model

// File: sim/tb_bus_cache_event_counting.sv
// Self-checking bench for the bus and cache event counter
`timescale 1ns/1ps
module tb_bus_cache_event_counting;
  typedef struct {string name; logic [32:0] val;} exp_t;
  logic                      clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]               paddr = 12'h000;
  logic [31:0]               pwdata = 32'h0000_0000, prdata, v1, v2, junk, rnd;
  logic                      pready, pslverr, pf_accept, pf_drop;
  logic [9:0]                ev = 10'h000;
  logic [27:0]               tbl [12];
  bus_event_pkg::bus_req_t   req_in = '0, req_grant;
  bus_event_pkg::bus_obs_t   obs;
  bus_event_pkg::bus_drive_t drive;
  exp_t                      exp_q[$];
  exp_t                      e;
  int                        error_cnt = 0, n_checks = 0, cyc = 0, drops = 0, accs = 0, hold_cyc = 0, n;
  int                        nn [12];
  integer                    seed = 32'h9b0c_1f06;
  always #25 clk = ~clk;
  bus_cache_event_counting u_bus_cache_event_counting (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_in(req_in), .req_grant(req_grant), .obs(obs), .drive(drive), .own_data(ev[7]), .lock_uc(ev[6]),
    .lock_split(ev[5]), .lock_walk(ev[4]), .pf_req(ev[9]), .l2_busy(ev[8]), .pf_accept(pf_accept),
    .pf_drop(pf_drop));
  bus_agents_model u_bus_agents_model (.clk(clk), .rst_n(rst_n), .cmd(ev[3:0]), .drive(drive), .obs(obs));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watches the outputs and compares each read against the oldest note
  always @(posedge clk)
  begin
    cyc++;
    if (drive.hold_off === 1'b1) hold_cyc++;
    if (pf_drop === 1'b1) drops++;
    if (pf_accept === 1'b1) accs++;
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check(e.name, e.val, {pslverr, prdata});
    end
    if (cyc > 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  // ****************************************
  // Stimulus tasks
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, junk);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [32:0] exp);
    exp_q.push_back('{what, exp});
    apb(1'b0, a, 32'h0000_0000, junk);
  endtask
  task automatic fire(input logic [9:0] bits, input int cnt);
    @(posedge clk);
    ev <= bits;
    repeat (cnt) @(posedge clk);
    ev <= 10'h000;
    repeat (4) @(posedge clk);
  endtask
  task automatic meas(input string what, input logic [27:0] t, input int cnt, input logic [31:0] exp);
    wr(bus_event_pkg::OFF_SELECT, {14'h0000, 2'b01, t[19:12], t[27:20]});
    wr(bus_event_pkg::OFF_COUNT, 32'h0000_0000);
    fire(t[11:2], cnt);
    rd_chk(what, bus_event_pkg::OFF_COUNT, {1'b0, exp});
  endtask
  task automatic issue(input bus_event_pkg::req_kind_t k, input logic c);
    @(posedge clk);
    req_in <= '{valid: 1'b1, kind: k, cacheable: c};
    @(posedge clk);
    req_in <= '0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    tbl = '{{8'h62, 8'h40, 10'h080, 2'd1}, {8'h62, 8'h40, 10'h002, 2'd0}, {8'h62, 8'hc0, 10'h002, 2'd1},
            {8'h62, 8'hc0, 10'h080, 2'd1}, {8'h63, 8'h40, 10'h040, 2'd1}, {8'h63, 8'hc0, 10'h020, 2'd1},
            {8'h63, 8'h40, 10'h010, 2'd1}, {8'h64, 8'h40, 10'h004, 2'd1}, {8'h5a, 8'h40, 10'h0f6, 2'd0},
            {8'h64, 8'hc0, 10'h004, 2'd0}, {8'h4e, 8'h10, 10'h300, 2'd1}, {8'h4e, 8'h10, 10'h200, 2'd1}};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("select reset", bus_event_pkg::OFF_SELECT, 33'h0_0000_0000);
    rd_chk("count reset", bus_event_pkg::OFF_COUNT, 33'h0_0000_0000);
    rd_chk("thresh reset", bus_event_pkg::OFF_THRESH, 33'h0_0000_000c);
    rd_chk("status reset", bus_event_pkg::OFF_STATUS, 33'h0_0000_0000);
    rd_chk("unmapped", 12'h010, 33'h1_0000_0000);
    rnd = $random(seed);
    wr(bus_event_pkg::OFF_COUNT, rnd);
    rd_chk("count rw", bus_event_pkg::OFF_COUNT, {1'b0, rnd});
    for (int i = 0; i < 12; i++)
    begin
      nn[i] = 1 + ($unsigned($random(seed)) % 8);
      meas($sformatf("event %0d", i), tbl[i], nn[i], nn[i] * tbl[i][1:0]);
    end
    check("refused prefetches", drops, nn[10]);
    check("accepted prefetches", accs, nn[11]);
    wr(bus_event_pkg::OFF_SELECT, {14'h0000, 2'b11, bus_event_pkg::UM_PREFETCH, bus_event_pkg::EV_PREFETCH});
    wr(bus_event_pkg::OFF_COUNT, 32'h0000_0000);
    fire(10'h300, 3);
    rd_chk("retried prefetches", bus_event_pkg::OFF_COUNT, 33'h0_0000_0004);
    check("retry accepted", accs, nn[11] + 1);
    check("retry not dropped", drops, nn[10]);
    wr(bus_event_pkg::OFF_THRESH, 32'h0000_0003);
    meas("hold-off", {8'h61, 8'h40, 10'h008, 2'd1}, 1, 1);
    check("hold-off cycles", hold_cyc, 2);
    wr(bus_event_pkg::OFF_SELECT, {14'h0000, 2'b01, bus_event_pkg::UM_OWN, bus_event_pkg::EV_BURST_READ});
    wr(bus_event_pkg::OFF_COUNT, 32'h0000_0000);
    for (int k = 0; k < 5; k++)
      issue(bus_event_pkg::req_kind_t'(k), 1'b1);
    issue(bus_event_pkg::REQ_L1D_READ, 1'b0);
    repeat (4) @(posedge clk);
    rd_chk("burst reads", bus_event_pkg::OFF_COUNT, 33'h0_0000_0003);
    rd_chk("pending reads", bus_event_pkg::OFF_STATUS, 33'h0_0000_0002);
    wr(bus_event_pkg::OFF_SELECT, {14'h0000, 2'b01, bus_event_pkg::UM_OWN, bus_event_pkg::EV_OUTSTANDING});
    apb(1'b0, bus_event_pkg::OFF_COUNT, 32'h0000_0000, v1);
    apb(1'b0, bus_event_pkg::OFF_COUNT, 32'h0000_0000, v2);
    check("pending sum", {1'b0, v2 - v1}, 33'h0_0000_0006);
    fire(10'h001, 2);
    rd_chk("pending drained", bus_event_pkg::OFF_STATUS, 33'h0_0000_0000);
    give_verdict();
  end
endmodule // tb_bus_cache_event_counting
